// ===== core/pft_defs.svh
// register map, field positions, reset values and timing counts
`ifndef PFT_DEFS_SVH
`define PFT_DEFS_SVH

// register indices; byte address is four times the index
`define PFT_IDX_SRC_SEL 6'h12
`define PFT_IDX_CMP_SEL 6'h13
`define PFT_IDX_ACT_CTL 6'h14
`define PFT_IDX_INT_EN 6'h15
`define PFT_IDX_FLAGS 6'h16
`define PFT_IDX_CLEAR 6'h17
`define PFT_IDX_FORCE 6'h18

// trip_source_select fields
`define PFT_SEL_CYC_LSB 0
`define PFT_SEL_CYC_CA2 6
`define PFT_SEL_CYC_CB2 7
`define PFT_SEL_SHOT_LSB 8
`define PFT_SEL_SHOT_CA1 14
`define PFT_SEL_SHOT_CB1 15

// trip_action_control fields, two bits each
`define PFT_ACT_A_LSB 0
`define PFT_ACT_B_LSB 2
`define PFT_ACT_DC_LSB 4

// flag, clear, force and enable bit positions
`define PFT_FLG_INT 0
`define PFT_FLG_CYC 1
`define PFT_FLG_SHOT 2
`define PFT_FLG_DC_LSB 3

// compare event modes, three bits per event
`define PFT_DCM_HI_LOW 3'h1
`define PFT_DCM_HI_HIGH 3'h2
`define PFT_DCM_LO_LOW 3'h3
`define PFT_DCM_LO_HIGH 3'h4
`define PFT_DCM_LO_HIGH_HI_LOW 3'h5

// reset values
`define PFT_REG_RST 16'h0000
`define PFT_FAULT_IDLE 6'h3f

// timing: timebase clock runs at the system clock rate here
`define PFT_CLK_NS 8
`define PFT_TB_CLK_NS 8
`define PFT_MIN_TRIP_TB_CLK 3
`define PFT_MIN_TRIP_CYC \
  ((`PFT_MIN_TRIP_TB_CLK * `PFT_TB_CLK_NS + `PFT_CLK_NS - 1) / `PFT_CLK_NS)

`endif

// ===== core/pft_pkg.sv
// shared types of the fault trip unit
package pft_pkg;

  // per-output trip action code
  typedef enum logic [1:0] {
    PFT_ACT_HIZ,
    PFT_ACT_HIGH,
    PFT_ACT_LOW,
    PFT_ACT_KEEP
  } pft_action_t;

endpackage : pft_pkg

// ===== core/pft_sync2.sv
// two-flop level synchroniser for a bus of independent bits
`timescale 1ns/1ns

module pft_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  // first stage feeds only the second stage
  always_comb begin
    meta_nxt = d;
    q_nxt = meta_r;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= RST;
      q_r <= RST;
    end else begin
      meta_r <= meta_nxt;
      q_r <= q_nxt;
    end
  end

  assign q = q_r;

endmodule : pft_sync2

// ===== core/pft_trip.sv
// fault trip unit for one pwm output pair with an apb register slave
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ns
`include "pft_defs.svh"

// Notes on behaviour
// (R1) six fault inputs, each usable by this instance
// (R2) inputs 1-3 pins, 4 inverted encoder error, 5 clock fail, 6 halt
// (R3) fault inputs are active low; low on an enabled input trips
// (R4) source select register enables or ignores every input and event; here it gates every input and routes events, direct compare events ignore it
// (R5) sources hold a fault low at least three timebase clocks
// (R6) asynchronous path trips outputs even without a clock; here only async_trip does, pwm outputs trip on the next clock edge
// (R7) each input selectable as per-cycle or single-shot source
// (R8) event one: direct or single-shot; event two: direct or per-cycle
// (R9) per-cycle trip acts at once, sets flag, interrupt if enabled
// (R10) event two on per-cycle path interrupts via per-cycle enable
// (R11) per-cycle trip releases at counter zero if fault has gone
// (R12) per-cycle flag stays until cleared, sets again if fault remains
// (R13) single-shot trip acts at once, sets flag, interrupt if enabled
// (R14) single-shot trip stays latched until its clear bit is written
// (R15) event one on single-shot path interrupts via single-shot enable
// (R16) compare events combine high and low compare signals per mode
// (R17) compare event applies own action, sets own flag, interrupts
// (R18) direct event trip follows event; flag sticky, re-set if present
// (R19) action code: 0 high-z, 1 high, 2 low, 3 unchanged
// (R20) register writes only take effect while unlock is asserted
// (R21) force register produces trips like hardware events
// (R22) all enabled trip flags combine onto one fault interrupt
// (R23) clear writes of one clear flags; clear and force read zero
// (R24) global flag blocks further interrupt pulses until cleared
module pft_trip
  import pft_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic protect_unlock,
  input wire logic [2:0] fault_input_n,
  input wire logic encoder_error,
  input wire logic clock_fail_n,
  input wire logic debug_halt_signal_n,
  input wire logic compare_a_high_signal,
  input wire logic compare_a_low_signal,
  input wire logic compare_b_high_signal,
  input wire logic compare_b_low_signal,
  input wire logic timebase_zero,
  input wire logic pwm_in_a,
  input wire logic pwm_in_b,
  output logic pwm_output_a,
  output logic pwm_output_a_oe,
  output logic pwm_output_b,
  output logic pwm_output_b_oe,
  output logic async_trip,
  output logic fault_interrupt
);

  // register state
  logic [15:0] src_sel_r;
  logic [15:0] src_sel_nxt;
  logic [15:0] cmp_sel_r;
  logic [15:0] cmp_sel_nxt;
  logic [15:0] act_ctl_r;
  logic [15:0] act_ctl_nxt;
  logic [15:0] int_en_r;
  logic [15:0] int_en_nxt;
  logic [6:0] flags_r;
  logic [6:0] flags_nxt;
  logic cyc_r;
  logic cyc_nxt;
  logic shot_r;
  logic shot_nxt;
  logic async_r;
  logic irq_r;
  logic irq_nxt;

  // apb answer state
  logic pready_r;
  logic pready_nxt;
  logic pslverr_r;
  logic pslverr_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;

  // output path state
  logic out_a_r;
  logic out_a_nxt;
  logic oe_a_r;
  logic oe_a_nxt;
  logic out_b_r;
  logic out_b_nxt;
  logic oe_b_r;
  logic oe_b_nxt;

  // combinational terms
  logic [5:0] fault_raw_n;
  logic [5:0] fault_n;
  logic [5:0] fault;
  logic [3:0] cmp_sync;
  logic [3:0] dc_ev;
  logic [3:0] dc_hit;
  logic [3:0] dc_routed;
  logic [3:0] dc_direct;
  logic async_hit;
  logic cyc_src;
  logic shot_src;
  logic [6:0] flag_set;
  logic [6:0] clr_bits;
  logic [6:0] frc_bits;
  logic [5:0] idx;
  logic map_ok;
  logic xfer_done;
  logic wr_ok;
  logic [15:0] rd_word;

  // fault input assembly; input four is the inverted encoder error
  assign fault_raw_n = {debug_halt_signal_n, clock_fail_n, ~encoder_error,
                        fault_input_n}; // [R1] [R2]

  // pins and comparator outputs come from outside this clock domain
  pft_sync2 #(
    .W(10),
    .RST({`PFT_FAULT_IDLE, 4'h0})
  ) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .d({fault_raw_n, compare_a_high_signal, compare_a_low_signal,
        compare_b_high_signal, compare_b_low_signal}),
    .q({fault_n, cmp_sync})
  );

  assign fault = ~fault_n; // [R3]

  // compare event mode decode
  function automatic logic dc_eval(
    input logic [2:0] mode,
    input logic hi,
    input logic lo
  );
    logic r;
    r = 1'b0;
    case (mode)
      `PFT_DCM_HI_LOW: r = ~hi;
      `PFT_DCM_HI_HIGH: r = hi;
      `PFT_DCM_LO_LOW: r = ~lo;
      `PFT_DCM_LO_HIGH: r = lo;
      `PFT_DCM_LO_HIGH_HI_LOW: r = lo & ~hi;
      default: r = 1'b0;
    endcase
    return r;
  endfunction : dc_eval

  // events 0,1 use channel a, events 2,3 channel b; mode 0 disables
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_dc
      assign dc_ev[gi] = dc_eval(cmp_sel_r[3*gi +: 3],
                                 cmp_sync[3 - 2*(gi/2)],
                                 cmp_sync[2 - 2*(gi/2)]); // [R16]
      assign dc_hit[gi] = dc_ev[gi] | frc_bits[`PFT_FLG_DC_LSB + gi];
      assign dc_direct[gi] = dc_hit[gi] & ~dc_routed[gi]; // [R8] [R18]
    end
  endgenerate

  // event one may go to single-shot, event two to per-cycle
  assign dc_routed = {src_sel_r[`PFT_SEL_CYC_CB2],
                      src_sel_r[`PFT_SEL_SHOT_CB1],
                      src_sel_r[`PFT_SEL_CYC_CA2],
                      src_sel_r[`PFT_SEL_SHOT_CA1]}; // [R8]

  // trip sources gathered per latch type
  always_comb begin
    cyc_src = |(fault & src_sel_r[`PFT_SEL_CYC_LSB +: 6])
            | (dc_hit[1] & dc_routed[1])
            | (dc_hit[3] & dc_routed[3])
            | frc_bits[`PFT_FLG_CYC]; // [R4] [R7] [R21]
    shot_src = |(fault & src_sel_r[`PFT_SEL_SHOT_LSB +: 6])
             | (dc_hit[0] & dc_routed[0])
             | (dc_hit[2] & dc_routed[2])
             | frc_bits[`PFT_FLG_SHOT]; // [R4] [R7] [R21]
  end

  // raw pin level, no clock needed; glitches here only force a trip
  assign async_hit = |(~fault_raw_n & (src_sel_r[`PFT_SEL_CYC_LSB +: 6]
                     | src_sel_r[`PFT_SEL_SHOT_LSB +: 6])); // [R6]

  // apb decode; one wait state so every answer is a flop
  always_comb begin
    idx = paddr[7:2];
    map_ok = (paddr[1:0] == 2'h0) && (idx >= `PFT_IDX_SRC_SEL)
             && (idx <= `PFT_IDX_FORCE);
    xfer_done = psel & penable & pready_r;
    wr_ok = xfer_done & pwrite & map_ok & protect_unlock; // [R20]
  end

  // read mux; clear and force always read zero
  always_comb begin
    rd_word = 16'h0000;
    case (idx)
      `PFT_IDX_SRC_SEL: rd_word = src_sel_r;
      `PFT_IDX_CMP_SEL: rd_word = cmp_sel_r;
      `PFT_IDX_ACT_CTL: rd_word = act_ctl_r;
      `PFT_IDX_INT_EN: rd_word = int_en_r;
      `PFT_IDX_FLAGS: rd_word = {9'h000, flags_r};
      default: rd_word = 16'h0000; // [R23]
    endcase
  end

  // clear and force strobes act only in the completing cycle
  always_comb begin
    clr_bits = 7'h00;
    frc_bits = 7'h00;
    if (wr_ok && idx == `PFT_IDX_CLEAR) begin
      clr_bits = pwdata[6:0]; // [R23]
    end
    if (wr_ok && idx == `PFT_IDX_FORCE) begin
      frc_bits = {pwdata[6:1], 1'b0}; // [R21]
    end
  end

  // configuration registers and apb answer
  always_comb begin
    src_sel_nxt = src_sel_r;
    cmp_sel_nxt = cmp_sel_r;
    act_ctl_nxt = act_ctl_r;
    int_en_nxt = int_en_r;
    if (wr_ok) begin
      case (idx)
        `PFT_IDX_SRC_SEL: src_sel_nxt = pwdata[15:0]; // [R4]
        `PFT_IDX_CMP_SEL: cmp_sel_nxt = pwdata[15:0];
        `PFT_IDX_ACT_CTL: act_ctl_nxt = pwdata[15:0];
        `PFT_IDX_INT_EN: int_en_nxt = {9'h000, pwdata[6:1], 1'b0};
        default: ;
      endcase
    end
    pready_nxt = psel & penable & ~pready_r;
    pslverr_nxt = psel & penable & ~pready_r & ~map_ok;
    prdata_nxt = 32'h0000_0000;
    if (psel && penable && !pready_r && !pwrite && map_ok) begin
      prdata_nxt = {16'h0000, rd_word};
    end
  end

  // trip latches, sticky flags and the interrupt pulse
  always_comb begin
    // per-cycle latch holds across a zero while the source persists
    cyc_nxt = cyc_src | (cyc_r & ~timebase_zero); // [R11]
    // single-shot ignores the counter; set wins over a same-cycle clear
    shot_nxt = shot_src | (shot_r & ~clr_bits[`PFT_FLG_SHOT]); // [R14]
    flag_set = {dc_hit, shot_src, cyc_src, 1'b0}; // [R9] [R13] [R17]
    flags_nxt[6:1] = (flags_r[6:1] & ~clr_bits[6:1])
                     | flag_set[6:1]; // [R12] [R18] [R23]
    // one pulse per global flag; enabled flags all feed the one line
    irq_nxt = ~flags_r[`PFT_FLG_INT]
              & |(flags_nxt[6:1] & int_en_r[6:1]); // [R10] [R15] [R22]
    flags_nxt[`PFT_FLG_INT] = irq_nxt | (flags_r[`PFT_FLG_INT]
                              & ~clr_bits[`PFT_FLG_INT]); // [R24]
  end

  // resolve one output: action code applied to the normal pwm level
  function automatic logic [1:0] apply_act(
    input logic [1:0] code,
    input logic pwm
  );
    logic [1:0] r;
    r = {1'b1, pwm};
    case (pft_action_t'(code))
      PFT_ACT_HIZ: r = 2'b00;
      PFT_ACT_HIGH: r = 2'b11;
      PFT_ACT_LOW: r = 2'b10;
      PFT_ACT_KEEP: r = {1'b1, pwm};
      default: r = {1'b1, pwm};
    endcase
    return r; // {oe, level}
  endfunction : apply_act

  // latch trips override direct events; the source terms act at once
  always_comb begin
    logic trip;
    logic [1:0] code_a;
    logic [1:0] code_b;
    trip = cyc_r | shot_r | cyc_src | shot_src | async_r; // [R9] [R13]
    code_a = 2'h3;
    code_b = 2'h3;
    if (trip) begin
      code_a = act_ctl_r[`PFT_ACT_A_LSB +: 2];
      code_b = act_ctl_r[`PFT_ACT_B_LSB +: 2];
    end else begin
      if (dc_direct[1]) begin
        code_a = act_ctl_r[`PFT_ACT_DC_LSB + 2 +: 2]; // [R17]
      end
      if (dc_direct[0]) begin
        code_a = act_ctl_r[`PFT_ACT_DC_LSB +: 2];
      end
      if (dc_direct[3]) begin
        code_b = act_ctl_r[`PFT_ACT_DC_LSB + 6 +: 2];
      end
      if (dc_direct[2]) begin
        code_b = act_ctl_r[`PFT_ACT_DC_LSB + 4 +: 2];
      end
    end
    {oe_a_nxt, out_a_nxt} = apply_act(code_a, pwm_in_a); // [R19]
    {oe_b_nxt, out_b_nxt} = apply_act(code_b, pwm_in_b); // [R19]
  end

  // asynchronous trip: set from the pin itself, cleared on a clock
  // once the pin has returned high; the clocked latches take over
  always_ff @(posedge clock or negedge rst_n or posedge async_hit) begin
    if (!rst_n) begin
      async_r <= 1'b0;
    end else if (async_hit) begin
      async_r <= 1'b1; // [R6]
    end else begin
      async_r <= 1'b0;
    end
  end

  // register everything except the asynchronous trip flop
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      src_sel_r <= `PFT_REG_RST;
      cmp_sel_r <= `PFT_REG_RST;
      act_ctl_r <= `PFT_REG_RST;
      int_en_r <= `PFT_REG_RST;
      flags_r <= 7'h00;
      cyc_r <= 1'b0;
      shot_r <= 1'b0;
      irq_r <= 1'b0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      out_a_r <= 1'b0;
      oe_a_r <= 1'b0;
      out_b_r <= 1'b0;
      oe_b_r <= 1'b0;
    end else begin
      src_sel_r <= src_sel_nxt;
      cmp_sel_r <= cmp_sel_nxt;
      act_ctl_r <= act_ctl_nxt;
      int_en_r <= int_en_nxt;
      flags_r <= flags_nxt;
      cyc_r <= cyc_nxt;
      shot_r <= shot_nxt;
      irq_r <= irq_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
      out_a_r <= out_a_nxt;
      oe_a_r <= oe_a_nxt;
      out_b_r <= out_b_nxt;
      oe_b_r <= oe_b_nxt;
    end
  end

  // outputs straight from flops
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign pwm_output_a = out_a_r;
  assign pwm_output_a_oe = oe_a_r;
  assign pwm_output_b = out_b_r;
  assign pwm_output_b_oe = oe_b_r;
  assign async_trip = async_r;
  assign fault_interrupt = irq_r;

endmodule : pft_trip

// ===== test/pft_fault_src.sv
// behavioural fault sources and compare signals facing the trip unit
`timescale 1ns/1ns
`include "pft_defs.svh"
module pft_fault_src (
  input wire logic clock,
  input wire logic [5:0] fault_req,
  input wire logic [3:0] cmp_req,
  output logic [2:0] fault_input_n,
  output logic encoder_error,
  output logic clock_fail_n,
  output logic debug_halt_signal_n,
  output logic compare_a_high_signal,
  output logic compare_a_low_signal,
  output logic compare_b_high_signal,
  output logic compare_b_low_signal
);
  int unsigned hold_cnt [6];
  logic [5:0] held;

  // a raised fault stays for the minimum low time, so short requests latch
  always @(posedge clock) begin
    for (int i = 0; i < 6; i++) begin
      if (fault_req[i]) begin
        hold_cnt[i] <= `PFT_MIN_TRIP_CYC;
      end else if (hold_cnt[i] != 0) begin
        hold_cnt[i] <= hold_cnt[i] - 1;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 6; i++) begin
      held[i] = fault_req[i] || hold_cnt[i] != 0;
    end
  end

  // pins are active low; encoder error arrives active high
  assign fault_input_n = ~held[2:0];
  assign encoder_error = held[3];
  assign clock_fail_n = ~held[4];
  assign debug_halt_signal_n = ~held[5];
  // compare signals follow the bench request directly
  assign {compare_b_low_signal, compare_b_high_signal,
    compare_a_low_signal, compare_a_high_signal} = cmp_req;
endmodule : pft_fault_src

// ===== test/pft_trip_assertions.sv
// port-level protocol and trip checks for the fault trip unit
`timescale 1ns/1ns
`include "pft_defs.svh"
module pft_trip_assertions (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [2:0] fault_input_n,
  input wire logic encoder_error,
  input wire logic clock_fail_n,
  input wire logic debug_halt_signal_n,
  input wire logic async_trip,
  input wire logic fault_interrupt
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // helper terms: decoded address and all raw fault pins idle
  wire logic mapped = paddr[1:0] == 2'b00 &&
    paddr[7:2] >= `PFT_IDX_SRC_SEL && paddr[7:2] <= `PFT_IDX_FORCE;
  wire logic idle = &fault_input_n & ~encoder_error & clock_fail_n &
    debug_halt_signal_n;

  property p_rdy_pulse;
    pready |=> !pready;
  endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready too long");
  property p_rdy_access;
    pready |-> psel && penable;
  endproperty
  a_rdy_access: assert property (p_rdy_access) else $error("stray pready");
  property p_rdy_time;
    $rose(psel && penable) |=> pready;
  endproperty
  a_rdy_time: assert property (p_rdy_time) else $error("pready late");
  property p_err_bad;
    pready && !mapped |-> pslverr;
  endproperty
  a_err_bad: assert property (p_err_bad) else $error("no slave error");
  property p_err_good;
    pready && mapped |-> !pslverr;
  endproperty
  a_err_good: assert property (p_err_good) else $error("false error");
  property p_rdata_idle;
    !pready |-> prdata == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("prdata not 0");
  property p_irq_pulse;
    fault_interrupt |=> !fault_interrupt;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq held");
  property p_async_rel;
    idle [*2] |-> !async_trip;
  endproperty
  a_async_rel: assert property (p_async_rel) else $error("async stuck");
  property p_async_cause;
    $rose(async_trip) |-> !idle;
  endproperty
  a_async_cause: assert property (p_async_cause) else $error("async no cause");
endmodule : pft_trip_assertions

bind pft_trip pft_trip_assertions pft_trip_assertions_i (
  .clock, .rst_n, .paddr, .psel, .penable, .prdata, .pready, .pslverr,
  .fault_input_n, .encoder_error, .clock_fail_n, .debug_halt_signal_n,
  .async_trip, .fault_interrupt);

// ===== test/tb_pft_trip.sv
// self-checking bench for the fault trip unit
`timescale 1ns/1ns
`include "pft_defs.svh"
module tb_pft_trip;
  logic clock = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic protect_unlock = 1, timebase_zero = 0, pwm_in_a = 1, pwm_in_b = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic pready, pslverr, rerr, async_trip, fault_interrupt, encoder_error;
  logic pwm_output_a, pwm_output_a_oe, pwm_output_b, pwm_output_b_oe;
  logic clock_fail_n, debug_halt_signal_n;
  logic compare_a_high_signal, compare_a_low_signal;
  logic compare_b_high_signal, compare_b_low_signal;
  logic [2:0] fault_input_n;
  logic [5:0] fault_req = 6'h00;
  logic [3:0] cmp_req = 4'h0;
  int num_errors = 0, tests_run = 0, irq_cnt = 0;
  // output level only matters while driven
  wire [3:0] pw = {pwm_output_a_oe, pwm_output_a & pwm_output_a_oe,
    pwm_output_b_oe, pwm_output_b & pwm_output_b_oe};
  localparam logic [7:0] A_SRC = {`PFT_IDX_SRC_SEL, 2'b00};
  localparam logic [7:0] A_CMP = {`PFT_IDX_CMP_SEL, 2'b00};
  localparam logic [7:0] A_ACT = {`PFT_IDX_ACT_CTL, 2'b00};
  localparam logic [7:0] A_INT = {`PFT_IDX_INT_EN, 2'b00};
  localparam logic [7:0] A_FLG = {`PFT_IDX_FLAGS, 2'b00};
  localparam logic [7:0] A_CLR = {`PFT_IDX_CLEAR, 2'b00};
  localparam logic [7:0] A_FRC = {`PFT_IDX_FORCE, 2'b00};

  pft_trip pft_trip_i (.clock, .rst_n, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .protect_unlock, .fault_input_n,
    .encoder_error, .clock_fail_n, .debug_halt_signal_n,
    .compare_a_high_signal, .compare_a_low_signal, .compare_b_high_signal,
    .compare_b_low_signal, .timebase_zero, .pwm_in_a, .pwm_in_b,
    .pwm_output_a, .pwm_output_a_oe, .pwm_output_b, .pwm_output_b_oe,
    .async_trip, .fault_interrupt);
  pft_fault_src pft_fault_src_i (.clock, .fault_req, .cmp_req,
    .fault_input_n, .encoder_error, .clock_fail_n, .debug_halt_signal_n,
    .compare_a_high_signal, .compare_a_low_signal, .compare_b_high_signal,
    .compare_b_low_signal);

  always #4 clock = ~clock;
  // counts interrupt pulses as the edge samples them
  always @(posedge clock) if (fault_interrupt === 1'b1) irq_cnt <= irq_cnt + 1;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic results();
    $display("mismatches %0d, checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [15:0] d);
    int n;
    @(posedge clock);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge clock);
    penable <= 1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rdata = prdata;
    rerr = pslverr;
    psel <= 0;
    penable <= 0;
    if (pready !== 1'b1) begin
      num_errors++;
      results();
    end
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    apb(1'b0, a, 16'h0000);
    check(rdata, {16'h0000, exp});
  endtask : rd

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick

  task automatic zero_pulse();
    timebase_zero <= 1;
    tick(1);
    timebase_zero <= 0;
    tick(2);
  endtask : zero_pulse

  // reset values, protected write, unmapped access
  task automatic regs_scenario();
    for (logic [7:0] a = A_SRC; a <= A_FRC; a += 8'h04) begin
      rd(a, 16'h0000);
    end
    protect_unlock <= 0;
    wr(A_SRC, 16'hffff);
    protect_unlock <= 1;
    rd(A_SRC, 16'h0000);
    apb(1'b0, 8'h40, 16'h0000);
    check(rerr, 1'b1);
  endtask : regs_scenario

  // per-cycle trip: unselected input ignored, release only at zero
  task automatic cycle_scenario();
    int irq0;
    wr(A_ACT, 16'h0006);
    wr(A_INT, 16'h0002);
    fault_req <= 6'h01;
    tick(5);
    check(pw, 4'b1110);
    fault_req <= 6'h00;
    tick(4);
    irq0 = irq_cnt;
    wr(A_SRC, 16'h0001);
    fault_req <= 6'h01;
    tick(1);
    check(async_trip, 1'b1);
    tick(4);
    check(pw, 4'b1011);
    rd(A_FLG, 16'h0003);
    fault_req <= 6'h00;
    tick(6);
    check(pw, 4'b1011);
    fault_req <= 6'h01;
    tick(6);
    wr(A_CLR, 16'h0002);
    rd(A_FLG, 16'h0003);
    check(irq_cnt - irq0, 1);
    fault_req <= 6'h00;
    tick(6);
    zero_pulse();
    check(pw, 4'b1110);
    wr(A_CLR, 16'h0003);
    rd(A_FLG, 16'h0000);
  endtask : cycle_scenario

  // every input as single-shot source, with every action code
  task automatic shot_scenario();
    logic [3:0] pexp [4] = '{4'b0000, 4'b1111, 4'b1010, 4'b1110};
    int irq0;
    wr(A_INT, 16'h0004);
    for (int i = 0; i < 6; i++) begin
      irq0 = irq_cnt;
      wr(A_SRC, 16'h0100 << i);
      wr(A_ACT, 16'(5 * (i % 4)));
      fault_req <= 6'h01 << i;
      tick(1);
      fault_req <= 6'h00;
      tick(6);
      check(pw, pexp[i % 4]);
      zero_pulse();
      check(pw, pexp[i % 4]);
      rd(A_FLG, 16'h0005);
      check(irq_cnt - irq0, 1);
      wr(A_CLR, 16'h0005);
      tick(2);
      check(pw, 4'b1110);
    end
  endtask : shot_scenario

  // software force; write-only registers read zero
  task automatic force_scenario();
    wr(A_INT, 16'h0000);
    wr(A_ACT, 16'h0006);
    wr(A_FRC, 16'h0002);
    tick(2);
    check(pw, 4'b1011);
    wr(A_CLR, 16'h0000);
    rd(A_FLG, 16'h0002);
    rd(A_FRC, 16'h0000);
    rd(A_CLR, 16'h0000);
    zero_pulse();
    wr(A_CLR, 16'h0002);
    rd(A_FLG, 16'h0000);
  endtask : force_scenario

  // channel a event one trips directly in each compare mode
  task automatic dc_scenario();
    logic [1:0] tv [5] = '{2'b10, 2'b01, 2'b01, 2'b10, 2'b10};
    logic [1:0] nv [5] = '{2'b11, 2'b00, 2'b11, 2'b00, 2'b11};
    int irq0;
    wr(A_SRC, 16'h0000);
    wr(A_ACT, 16'h0020);
    wr(A_INT, 16'h0008);
    for (int m = 0; m < 5; m++) begin
      irq0 = irq_cnt;
      cmp_req <= {2'b00, nv[m]};
      wr(A_CMP, 16'(m + 1));
      tick(5);
      check(pw, 4'b1110);
      cmp_req <= {2'b00, tv[m]};
      tick(5);
      check(pw, 4'b1010);
      cmp_req <= {2'b00, nv[m]};
      tick(5);
      check(pw, 4'b1110);
      rd(A_FLG, 16'h0009);
      check(irq_cnt - irq0, 1);
      wr(A_CMP, 16'h0000);
      wr(A_CLR, 16'h0009);
    end
  endtask : dc_scenario

  // routed events: a event two per-cycle, b event one single-shot,
  // b event two stays direct with its own action and no interrupt
  task automatic route_scenario();
    int irq0;
    wr(A_INT, 16'h0006);
    wr(A_ACT, 16'h0406);
    wr(A_CMP, 16'h0890);
    wr(A_SRC, 16'h8040);
    irq0 = irq_cnt;
    cmp_req <= 4'b0001;
    tick(5);
    check(pw, 4'b1011);
    rd(A_FLG, 16'h0013);
    check(irq_cnt - irq0, 1);
    cmp_req <= 4'b0000;
    tick(5);
    zero_pulse();
    check(pw, 4'b1110);
    wr(A_CLR, 16'h0013);
    irq0 = irq_cnt;
    cmp_req <= 4'b0100;
    tick(5);
    cmp_req <= 4'b0000;
    tick(5);
    zero_pulse();
    check(pw, 4'b1011);
    rd(A_FLG, 16'h0025);
    check(irq_cnt - irq0, 1);
    wr(A_CLR, 16'h0025);
    cmp_req <= 4'b1000;
    tick(5);
    check(pw, 4'b1111);
    rd(A_FLG, 16'h0040);
    cmp_req <= 4'b0000;
    tick(5);
    check(pw, 4'b1110);
    wr(A_CMP, 16'h0000);
    wr(A_CLR, 16'h0040);
  endtask : route_scenario

  initial begin
    repeat (2) @(posedge clock);
    rst_n <= 1;
    regs_scenario();
    cycle_scenario();
    shot_scenario();
    force_scenario();
    dc_scenario();
    route_scenario();
    results();
  end
endmodule : tb_pft_trip
